/* File: src/iod_pkg.sv */
package iod_pkg;

  // clock rates and bus timing
  localparam int SYS_CLK_MHZ   = 50;
  localparam int BUS_CLK_MHZ   = 8;
  localparam int BUS_CLK_NS    = 125;
  localparam int BASE_CYCLE_NS = 250;
  localparam int IO_SLOW_NS    = 500;
  localparam int IO_FAST_NS    = 250;

  // phase accumulator: twice the bus clock rate, one toggle per wrap
  localparam logic [7:0] ACC_STEP = 8'(2 * BUS_CLK_MHZ);
  localparam logic [7:0] ACC_WRAP = 8'(SYS_CLK_MHZ);

  // cycle lengths in bus clock periods
  localparam logic [2:0] BASE_TICKS = 3'(BASE_CYCLE_NS / BUS_CLK_NS);
  localparam logic [2:0] SLOW_TICKS = 3'(IO_SLOW_NS / BUS_CLK_NS);
  localparam logic [2:0] FAST_TICKS = 3'(IO_FAST_NS / BUS_CLK_NS);

  // built-in wait states
  localparam logic [1:0] WAIT_MAX   = 2'h2;
  localparam logic [1:0] WAIT_RESET = 2'h2;

  // i/o space regions
  localparam logic [15:0] USER_LO = 16'h0010;
  localparam logic [15:0] USER_HI = 16'h3FFF;
  localparam logic [15:0] LCD1_LO = 16'h4000;
  localparam logic [15:0] LCD1_HI = 16'h40FF;
  localparam logic [15:0] LCD2_LO = 16'h4100;
  localparam logic [15:0] LCD2_HI = 16'h41FF;
  localparam logic [15:0] RTC_LO  = 16'h8000;
  localparam logic [15:0] RTC_HI  = 16'hBFFF;
  localparam logic [15:0] UART_LO = 16'hC000;
  localparam logic [15:0] UART_HI = 16'hC0FF;
  localparam logic [15:0] PPU_LO  = 16'hC100;
  localparam logic [15:0] PPU_HI  = 16'hC1FF;

  // select vector positions
  localparam int SEL_W    = 6;
  localparam int SEL_USER = 0;
  localparam int SEL_LCD1 = 1;
  localparam int SEL_LCD2 = 2;
  localparam int SEL_RTC  = 3;
  localparam int SEL_UART = 4;
  localparam int SEL_PPU  = 5;

  // parallel port registers
  localparam logic [15:0] PARALLEL_PORT_ZERO_DATA_ADDR    = 16'hC100;
  localparam logic [15:0] PARALLEL_PORT_ONE_DATA_ADDR     = 16'hC101;
  localparam logic [15:0] PARALLEL_PORT_TWO_DATA_ADDR     = 16'hC102;
  localparam logic [15:0] PARALLEL_PORT_MODE_COMMAND_ADDR = 16'hC103;
  localparam logic [7:0]  CMD_RESET = 8'h9F;
  localparam logic [7:0]  DATA_RESET = 8'h00;

  // command fields
  localparam int CMD_SET    = 7;
  localparam int CMD_AM_HI  = 6;
  localparam int CMD_AM_LO  = 5;
  localparam int CMD_P0_IN  = 4;
  localparam int CMD_P2U_IN = 3;
  localparam int CMD_BMODE  = 2;
  localparam int CMD_P1_IN  = 1;
  localparam int CMD_P2L_IN = 0;
  localparam int BSR_HI     = 3;
  localparam int BSR_LO     = 1;
  localparam int BSR_VAL    = 0;

  // handshake line positions within port two
  localparam int PC_STB_B = 2;
  localparam int PC_STB_A = 4;
  localparam int PC_ACK_A = 6;

  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'b00,
    ST_ALIGN  = 2'b01,
    ST_ACCESS = 2'b10,
    ST_DONE   = 2'b11
  } iod_state_t;

  typedef enum logic [1:0]
  {
    MODE_BASIC   = 2'b00,
    MODE_STROBED = 2'b01,
    MODE_BIDIR   = 2'b10
  } iod_mode_t;

endpackage

/* File: src/iod_sync.sv */
`timescale 1ns/1ps
module iod_sync #(
  parameter int W = 1
) (
  // clock
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_ff <= '0;
      q_ff    <= '0;
    end
    else if (ce)
    begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule

/* File: src/iod_decoder.sv */
`timescale 1ns/1ps
module iod_decoder (
  // access
  input  wire logic [15:0]                addr,
  input  wire logic                       io,
  // decode
  output logic      [iod_pkg::SEL_W-1:0]  sel,
  output logic                            slow
);

  function automatic logic in_rng(input logic [15:0] a,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // memory cycles and gaps between regions select nothing
  assign sel[iod_pkg::SEL_USER] =
    io & in_rng(addr, iod_pkg::USER_LO, iod_pkg::USER_HI);
  assign sel[iod_pkg::SEL_LCD1] =
    io & in_rng(addr, iod_pkg::LCD1_LO, iod_pkg::LCD1_HI);
  assign sel[iod_pkg::SEL_LCD2] =
    io & in_rng(addr, iod_pkg::LCD2_LO, iod_pkg::LCD2_HI);
  assign sel[iod_pkg::SEL_RTC] =
    io & in_rng(addr, iod_pkg::RTC_LO, iod_pkg::RTC_HI);
  assign sel[iod_pkg::SEL_UART] =
    io & in_rng(addr, iod_pkg::UART_LO, iod_pkg::UART_HI);
  assign sel[iod_pkg::SEL_PPU] =
    io & in_rng(addr, iod_pkg::PPU_LO, iod_pkg::PPU_HI);

  // whole 16-bit space is i/o when io is high; lower half is slow
  assign slow = io & ~addr[15];

endmodule

/* File: src/iod_bridge.sv */
`timescale 1ns/1ps
module iod_bridge (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        CE,
  // processor bus
  input  wire logic        BUS_START,
  input  wire logic        BUS_IO,
  input  wire logic        BUS_WR,
  input  wire logic [15:0] BUS_ADDR,
  input  wire logic [7:0]  BUS_WDATA,
  output logic      [7:0]  BUS_RDATA,
  output logic             BUS_DONE,
  output logic             READY_PORT_PIN,
  output logic             SYS_CLK_OUT,
  // wait setting
  input  wire logic        WAIT_LOAD,
  input  wire logic [1:0]  WAIT_SET,
  // peripheral selects
  output logic             USER_SEL,
  output logic             LCD_SELECT_FIRST,
  output logic             LCD_SELECT_SECOND,
  output logic             RTC_SEL,
  output logic             EXTERNAL_UART_ENABLE,
  output logic             PPU_SEL,
  input  wire logic        PERIPH_READY_N,
  // parallel lines
  input  wire logic [23:0] PP_IN,
  output logic      [23:0] PP_OUT,
  output logic      [23:0] PP_OE
);

  // pin synchronisation
  logic [24:0] sync_q;

  iod_sync #(.W(25)) u_sync (
    .clk (CLK_SYS),
    .rst (RST),
    .ce  (CE),
    .d   ({PERIPH_READY_N, PP_IN}),
    .q   (sync_q)
  );

  wire logic [23:0] pin_s   = sync_q[23:0];
  wire logic        per_rdy = ~sync_q[24];

  // bus clock from a phase accumulator: exact 8 MHz on average
  logic [6:0] acc_ff;
  logic       clk_out_ff;

  wire logic [7:0] acc_sum   = {1'b0, acc_ff} + iod_pkg::ACC_STEP;
  wire logic       half_tick = acc_sum >= iod_pkg::ACC_WRAP;
  wire logic [7:0] acc_wrap  = acc_sum - iod_pkg::ACC_WRAP;
  wire logic [6:0] nxt_acc   = half_tick ? acc_wrap[6:0] : acc_sum[6:0];
  // one tick per output period, on its falling toggle
  wire logic       bus_tick  = half_tick & clk_out_ff;

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      acc_ff     <= 7'h00;
      clk_out_ff <= 1'b0;
    end
    else if (CE)
    begin
      acc_ff     <= nxt_acc;
      clk_out_ff <= clk_out_ff ^ half_tick;
    end
  end

  // region decode
  logic [iod_pkg::SEL_W-1:0] dec_sel;
  logic                      dec_slow;

  iod_decoder u_dec (
    .addr (BUS_ADDR),
    .io   (BUS_IO),
    .sel  (dec_sel),
    .slow (dec_slow)
  );

  // wait setting, clamped to the generator's range
  logic [1:0] ws_ff;

  wire logic [1:0] nxt_ws = (WAIT_SET > iod_pkg::WAIT_MAX) ?
                            iod_pkg::WAIT_MAX : WAIT_SET;

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      ws_ff <= iod_pkg::WAIT_RESET;
    else if (CE && WAIT_LOAD)
      ws_ff <= nxt_ws;
  end

  // bus cycle sequencing
  iod_pkg::iod_state_t state_ff;
  iod_pkg::iod_state_t nxt_state;

  logic [2:0]                need_ff;
  logic [2:0]                cnt_ff;
  logic [15:0]               addr_ff;
  logic                      wr_ff;
  logic [7:0]                wdata_ff;
  logic [iod_pkg::SEL_W-1:0] sel_ff;
  logic                      ready_ff;
  logic                      done_ff;
  logic [7:0]                rdata_ff;

  wire logic       in_idle    = state_ff == iod_pkg::ST_IDLE;
  wire logic       in_align   = state_ff == iod_pkg::ST_ALIGN;
  wire logic       in_access  = state_ff == iod_pkg::ST_ACCESS;
  wire logic       start_ok   = BUS_START & in_idle;
  wire logic [2:0] base_need  = iod_pkg::BASE_TICKS + {1'b0, ws_ff};
  wire logic [2:0] floor_need = dec_slow ? iod_pkg::SLOW_TICKS
                                         : iod_pkg::FAST_TICKS;
  wire logic [2:0] start_need = (base_need > floor_need) ?
                                base_need : floor_need;
  wire logic       count_end  = in_access & (cnt_ff >= need_ff);
  // beyond the counted waits, hold until the ready pin releases
  wire logic       finish     = count_end & per_rdy;
  wire logic [2:0] cnt_inc    = cnt_ff + 3'h1;
  wire logic [2:0] nxt_cnt    = in_align ? 3'h0 :
                                (in_access & bus_tick & ~count_end) ?
                                cnt_inc : cnt_ff;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      iod_pkg::ST_IDLE:
        if (BUS_START)
          nxt_state = iod_pkg::ST_ALIGN;
      // wait for a period edge so every counted tick is a full period
      iod_pkg::ST_ALIGN:
        if (bus_tick)
          nxt_state = iod_pkg::ST_ACCESS;
      iod_pkg::ST_ACCESS:
        if (finish)
          nxt_state = iod_pkg::ST_DONE;
      iod_pkg::ST_DONE:
        nxt_state = iod_pkg::ST_IDLE;
      default:
        nxt_state = iod_pkg::ST_IDLE;
    endcase
  end

  wire logic [iod_pkg::SEL_W-1:0] nxt_sel =
    start_ok ? dec_sel : finish ? '0 : sel_ff;
  wire logic nxt_ready = start_ok ? 1'b0 : finish ? 1'b1 : ready_ff;

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      state_ff <= iod_pkg::ST_IDLE;
      cnt_ff   <= 3'h0;
      sel_ff   <= '0;
      ready_ff <= 1'b1;
      done_ff  <= 1'b0;
    end
    else if (CE)
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      sel_ff   <= nxt_sel;
      ready_ff <= nxt_ready;
      done_ff  <= finish;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      need_ff  <= 3'h0;
      addr_ff  <= 16'h0000;
      wr_ff    <= 1'b0;
      wdata_ff <= 8'h00;
    end
    else if (CE && start_ok)
    begin
      need_ff  <= start_need;
      addr_ff  <= BUS_ADDR;
      wr_ff    <= BUS_WR;
      wdata_ff <= BUS_WDATA;
    end
  end

  // parallel port register access at the end of the cycle
  wire logic ppu_acc = finish & sel_ff[iod_pkg::SEL_PPU];
  wire logic hit_p0  = addr_ff == iod_pkg::PARALLEL_PORT_ZERO_DATA_ADDR;
  wire logic hit_p1  = addr_ff == iod_pkg::PARALLEL_PORT_ONE_DATA_ADDR;
  wire logic hit_p2  = addr_ff == iod_pkg::PARALLEL_PORT_TWO_DATA_ADDR;
  wire logic hit_cmd = addr_ff == iod_pkg::PARALLEL_PORT_MODE_COMMAND_ADDR;
  wire logic wr_p0   = ppu_acc & wr_ff & hit_p0;
  wire logic wr_p1   = ppu_acc & wr_ff & hit_p1;
  wire logic wr_p2   = ppu_acc & wr_ff & hit_p2;
  wire logic wr_cmd  = ppu_acc & wr_ff & hit_cmd;
  wire logic rd_p0   = ppu_acc & ~wr_ff & hit_p0;
  wire logic rd_p1   = ppu_acc & ~wr_ff & hit_p1;
  wire logic mode_set = wr_cmd & wdata_ff[iod_pkg::CMD_SET];
  wire logic bit_op   = wr_cmd & ~wdata_ff[iod_pkg::CMD_SET];

  logic [7:0] cmd_ff;
  logic [7:0] port0_ff;
  logic [7:0] port1_ff;
  logic [7:0] port2_ff;
  logic [7:0] ina_ff;
  logic [7:0] inb_ff;
  logic       ibf_a_ff;
  logic       obf_a_ff;
  logic       ibf_b_ff;
  logic       obf_b_ff;
  logic [2:0] prev_ff;

  // mode decode; group A has three modes, group B two
  iod_pkg::iod_mode_t mode_a;
  assign mode_a = cmd_ff[iod_pkg::CMD_AM_HI] ? iod_pkg::MODE_BIDIR :
                  cmd_ff[iod_pkg::CMD_AM_LO] ? iod_pkg::MODE_STROBED :
                  iod_pkg::MODE_BASIC;

  wire logic p0_in  = cmd_ff[iod_pkg::CMD_P0_IN];
  wire logic p1_in  = cmd_ff[iod_pkg::CMD_P1_IN];
  wire logic p2u_in = cmd_ff[iod_pkg::CMD_P2U_IN];
  wire logic p2l_in = cmd_ff[iod_pkg::CMD_P2L_IN];
  // an all-input command forces group B to basic mode
  wire logic all_in = p0_in & p1_in & p2u_in & p2l_in;
  wire logic a_stb  = mode_a == iod_pkg::MODE_STROBED;
  wire logic a_bidir = mode_a == iod_pkg::MODE_BIDIR;
  wire logic a_hs   = a_stb | a_bidir;
  wire logic b_stb  = cmd_ff[iod_pkg::CMD_BMODE] & ~all_in;
  wire logic a_in_role  = (a_stb & p0_in) | a_bidir;
  wire logic a_out_role = (a_stb & ~p0_in) | a_bidir;

  // strobe and acknowledge edges on synchronised port two lines
  wire logic stb_a_n = pin_s[16 + iod_pkg::PC_STB_A];
  wire logic ack_a_n = pin_s[16 + iod_pkg::PC_ACK_A];
  wire logic hs_b_n  = pin_s[16 + iod_pkg::PC_STB_B];
  wire logic [2:0] hs_now  = {stb_a_n, ack_a_n, hs_b_n};
  wire logic [2:0] hs_fall = prev_ff & ~hs_now;
  wire logic stb_a_fall = hs_fall[2] & a_in_role;
  wire logic ack_a_fall = hs_fall[1] & a_out_role;
  wire logic stb_b_fall = hs_fall[0] & b_stb & p1_in;
  wire logic ack_b_fall = hs_fall[0] & b_stb & ~p1_in;

  // interrupt enables live in the port two latch
  wire logic inte_a_in  = port2_ff[iod_pkg::PC_STB_A];
  wire logic inte_a_out = port2_ff[iod_pkg::PC_ACK_A];
  wire logic inte_b     = port2_ff[iod_pkg::PC_STB_B];

  // a strobe or write in the same cycle as the clearing access wins
  wire logic nxt_ibf_a = ~mode_set & (stb_a_fall | (ibf_a_ff & ~rd_p0));
  wire logic nxt_obf_a = ~mode_set &
                         ((wr_p0 & a_out_role) | (obf_a_ff & ~ack_a_fall));
  wire logic nxt_ibf_b = ~mode_set & (stb_b_fall | (ibf_b_ff & ~rd_p1));
  wire logic nxt_obf_b = ~mode_set &
                         ((wr_p1 & b_stb & ~p1_in) | (obf_b_ff & ~ack_b_fall));

  wire logic intr_a = (a_in_role & ibf_a_ff & inte_a_in & stb_a_n) |
                      (a_out_role & ~obf_a_ff & inte_a_out & ack_a_n);
  wire logic intr_b = b_stb & inte_b & hs_b_n &
                      (p1_in ? ibf_b_ff : ~obf_b_ff);
  wire logic b_buf  = p1_in ? ibf_b_ff : ~obf_b_ff;

  // port two: handshake outputs, handshake inputs, handshake values
  wire logic [7:0] hs_out = {a_out_role, 1'b0, a_in_role, 1'b0,
                             a_hs, 1'b0, b_stb, b_stb};
  wire logic [7:0] hs_in  = {1'b0, a_out_role, 1'b0, a_in_role,
                             1'b0, b_stb, 2'b00};
  wire logic [7:0] hs_val = {~obf_a_ff, 1'b0, ibf_a_ff, 1'b0,
                             intr_a, 1'b0, b_buf, intr_b};
  wire logic [7:0] dir2   = {{4{p2u_in}}, {4{p2l_in}}};
  wire logic [7:0] p2_gen = ~hs_in & ~hs_out;
  wire logic [7:0] p2_oe  = hs_out | (p2_gen & ~dir2);
  wire logic [7:0] p2_drv = (hs_out & hs_val) | (~hs_out & port2_ff);
  // bidirectional port zero drives only while acknowledged
  wire logic [7:0] p0_oe  = {8{a_bidir ? ~ack_a_n : ~p0_in}};
  wire logic [7:0] p1_oe  = {8{~p1_in}};

  // bit set/reset of one port two line
  wire logic [2:0] bit_idx  = wdata_ff[iod_pkg::BSR_HI:iod_pkg::BSR_LO];
  wire logic [7:0] bit_mask = 8'h01 << bit_idx;
  wire logic [7:0] bit_new  = (port2_ff & ~bit_mask) |
                              ({8{wdata_ff[iod_pkg::BSR_VAL]}} & bit_mask);

  wire logic [7:0] nxt_port0 = mode_set ? iod_pkg::DATA_RESET :
                               wr_p0 ? wdata_ff : port0_ff;
  wire logic [7:0] nxt_port1 = mode_set ? iod_pkg::DATA_RESET :
                               wr_p1 ? wdata_ff : port1_ff;
  wire logic [7:0] nxt_port2 = mode_set ? iod_pkg::DATA_RESET :
                               bit_op ? bit_new :
                               wr_p2 ? wdata_ff : port2_ff;
  wire logic [7:0] nxt_cmd   = mode_set ? wdata_ff : cmd_ff;
  wire logic [7:0] nxt_ina   = stb_a_fall ? pin_s[7:0] : ina_ff;
  wire logic [7:0] nxt_inb   = stb_b_fall ? pin_s[15:8] : inb_ff;

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      cmd_ff   <= iod_pkg::CMD_RESET;
      port0_ff <= iod_pkg::DATA_RESET;
      port1_ff <= iod_pkg::DATA_RESET;
      port2_ff <= iod_pkg::DATA_RESET;
      ina_ff   <= iod_pkg::DATA_RESET;
      inb_ff   <= iod_pkg::DATA_RESET;
    end
    else if (CE)
    begin
      cmd_ff   <= nxt_cmd;
      port0_ff <= nxt_port0;
      port1_ff <= nxt_port1;
      port2_ff <= nxt_port2;
      ina_ff   <= nxt_ina;
      inb_ff   <= nxt_inb;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      ibf_a_ff <= 1'b0;
      obf_a_ff <= 1'b0;
      ibf_b_ff <= 1'b0;
      obf_b_ff <= 1'b0;
      prev_ff  <= 3'h0; // synchroniser resets low: no false edge
    end
    else if (CE)
    begin
      ibf_a_ff <= nxt_ibf_a;
      obf_a_ff <= nxt_obf_a;
      ibf_b_ff <= nxt_ibf_b;
      obf_b_ff <= nxt_obf_b;
      prev_ff  <= hs_now;
    end
  end

  // read paths: strobed input reads the latch, basic input the lines
  wire logic [7:0] p0_rd = a_in_role ? ina_ff :
                           p0_in ? pin_s[7:0] : port0_ff;
  wire logic [7:0] p1_rd = (b_stb & p1_in) ? inb_ff :
                           p1_in ? pin_s[15:8] : port1_ff;
  wire logic [7:0] p2_in_mask = hs_in | (p2_gen & dir2);
  wire logic [7:0] p2_rd = (hs_out & hs_val) |
                           (p2_in_mask & pin_s[23:16]) |
                           (p2_gen & ~dir2 & port2_ff);
  // command register is write-only and reads as zero
  wire logic [7:0] ppu_rd = hit_p0 ? p0_rd :
                            hit_p1 ? p1_rd :
                            hit_p2 ? p2_rd : 8'h00;
  wire logic [7:0] nxt_rdata = sel_ff[iod_pkg::SEL_PPU] ? ppu_rd : 8'h00;

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      rdata_ff <= 8'h00;
    else if (CE && finish && !wr_ff)
      rdata_ff <= nxt_rdata;
  end

  logic [23:0] pp_out_ff;
  logic [23:0] pp_oe_ff;

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      pp_out_ff <= 24'h000000;
      pp_oe_ff  <= 24'h000000;
    end
    else if (CE)
    begin
      pp_out_ff <= {p2_drv, port1_ff, port0_ff};
      pp_oe_ff  <= {p2_oe, p1_oe, p0_oe};
    end
  end

  assign BUS_RDATA            = rdata_ff;
  assign BUS_DONE             = done_ff;
  assign READY_PORT_PIN       = ready_ff;
  assign SYS_CLK_OUT          = clk_out_ff;
  assign USER_SEL             = sel_ff[iod_pkg::SEL_USER];
  assign LCD_SELECT_FIRST     = sel_ff[iod_pkg::SEL_LCD1];
  assign LCD_SELECT_SECOND    = sel_ff[iod_pkg::SEL_LCD2];
  assign RTC_SEL              = sel_ff[iod_pkg::SEL_RTC];
  assign EXTERNAL_UART_ENABLE = sel_ff[iod_pkg::SEL_UART];
  assign PPU_SEL              = sel_ff[iod_pkg::SEL_PPU];
  assign PP_OUT               = pp_out_ff;
  assign PP_OE                = pp_oe_ff;

endmodule

/* File: testbench/iod_chk.sv */
`timescale 1ns/1ps
module iod_chk (
  // clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RST,
  // bus
  input wire logic        BUS_IO,
  input wire logic [15:0] BUS_ADDR,
  input wire logic        BUS_DONE,
  input wire logic        READY_PORT_PIN,
  input wire logic        SYS_CLK_OUT,
  // selects
  input wire logic        USER_SEL,
  input wire logic        LCD_SELECT_FIRST,
  input wire logic        LCD_SELECT_SECOND,
  input wire logic        RTC_SEL,
  input wire logic        EXTERNAL_UART_ENABLE,
  input wire logic        PPU_SEL
);
  logic [5:0] sel;
  logic [7:0] low_cnt_ff;
  logic [7:0] nxt_low_cnt;
  assign sel = {PPU_SEL, EXTERNAL_UART_ENABLE, RTC_SEL, LCD_SELECT_SECOND,
                LCD_SELECT_FIRST, USER_SEL};
  // cycles the ready pin has been held low in this access
  assign nxt_low_cnt = READY_PORT_PIN ? 8'h00 : low_cnt_ff + 8'h01;
  always_ff @(posedge CLK_SYS or posedge RST)
    if (RST)
      low_cnt_ff <= 8'h00;
    else
      low_cnt_ff <= nxt_low_cnt;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  a_sel_onehot: assert property ($onehot0(sel))
    else $error("two selects at once");
  a_mem_nosel: assert property ($rose(|sel) |-> $past(BUS_IO))
    else $error("select in memory cycle");
  a_ppu_win: assert property ($rose(PPU_SEL) |->
    ($past(BUS_ADDR) & 16'hFF00) == 16'hC100) else $error("ppu select");
  a_lcd_win: assert property ($rose(LCD_SELECT_SECOND) |->
    ($past(BUS_ADDR) & 16'hFF00) == 16'h4100) else $error("lcd select");
  a_sel_hold: assert property ($fell(|sel) |-> BUS_DONE)
    else $error("select dropped early");
  a_done_pulse: assert property (BUS_DONE |=> !BUS_DONE)
    else $error("done too long");
  a_ready_done: assert property ($rose(READY_PORT_PIN) |-> BUS_DONE)
    else $error("ready rose without done");
  a_slow_len: assert property (BUS_DONE && BUS_IO && !BUS_ADDR[15] |->
    low_cnt_ff >= 8'd24) else $error("slow access short");
  a_fast_len: assert property (BUS_DONE |-> low_cnt_ff >= 8'd11)
    else $error("access short");
  a_clk_half: assert property ($rose(SYS_CLK_OUT) |=>
    SYS_CLK_OUT [*2] ##[1:2] !SYS_CLK_OUT) else $error("bus clock");
  c_lcd: cover property ($rose(LCD_SELECT_FIRST));
  c_ppu: cover property ($rose(PPU_SEL) ##[1:60] BUS_DONE);
  c_stall: cover property ($rose(READY_PORT_PIN) && low_cnt_ff > 8'd40);
endmodule

bind iod_bridge iod_chk i_chk (.*);

/* File: testbench/iod_periph.sv */
`timescale 1ns/1ps
module iod_periph (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // select and stall length
  input wire logic        sel_any,
  input wire logic [7:0]  stall,
  // parallel lines
  input wire logic [23:0] pat,
  input wire logic [23:0] oe,
  input wire logic [23:0] dout,
  output logic            ready_n,
  output logic     [23:0] lines
);
  logic [7:0] cnt_ff;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      cnt_ff <= 8'h00;
    else
      cnt_ff <= sel_any ? cnt_ff + 8'h01 : 8'h00;
  // unselected, the pin rests at its ready level
  assign ready_n = sel_any && (cnt_ff < stall);
  assign lines = (oe & dout) | (~oe & pat);
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        start = 1'b0;
  logic        io = 1'b0;
  logic        wr = 1'b0;
  logic        wload = 1'b0;
  logic [1:0]  wset = 2'h0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  stall = 8'h00;
  logic [23:0] pat = 24'h5AC396;
  logic [7:0]  rdata;
  logic        done;
  logic        rdy;
  logic        sclk;
  logic        ready_n;
  logic [5:0]  sel;
  logic [23:0] pp_in;
  logic [23:0] pp_out;
  logic [23:0] pp_oe;
  int          n_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  localparam logic [15:0] TA [10] = '{16'h0010, 16'h3FFF, 16'h4000,
    16'h41FF, 16'h8000, 16'hC0FF, 16'hC1FF, 16'h000F, 16'hC200, 16'h4000};
  localparam logic [5:0] TM [10] = '{6'h01, 6'h01, 6'h02, 6'h04, 6'h08,
    6'h10, 6'h20, 6'h00, 6'h00, 6'h00};

  iod_bridge i_dut (
    .CLK_SYS(clk), .RST(rst), .CE(1'b1), .BUS_START(start), .BUS_IO(io),
    .BUS_WR(wr), .BUS_ADDR(addr), .BUS_WDATA(wdata), .BUS_RDATA(rdata),
    .BUS_DONE(done), .READY_PORT_PIN(rdy), .SYS_CLK_OUT(sclk),
    .WAIT_LOAD(wload), .WAIT_SET(wset), .USER_SEL(sel[0]),
    .LCD_SELECT_FIRST(sel[1]), .LCD_SELECT_SECOND(sel[2]),
    .RTC_SEL(sel[3]), .EXTERNAL_UART_ENABLE(sel[4]), .PPU_SEL(sel[5]),
    .PERIPH_READY_N(ready_n), .PP_IN(pp_in), .PP_OUT(pp_out), .PP_OE(pp_oe));
  iod_periph i_periph (.clk(clk), .rst(rst), .sel_any(|sel), .stall(stall),
    .pat(pat), .oe(pp_oe), .dout(pp_out), .ready_n(ready_n), .lines(pp_in));

  always #10 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // starts just after a bus tick so lengths vary by one cycle at most
  task automatic cyc(input logic i, w, input logic [15:0] a,
                     input logic [7:0] d, output int n, output logic [5:0] m);
    @(negedge sclk);
    @(posedge clk);
    #1;
    {start, io, wr, addr, wdata} = {1'b1, i, w, a, d};
    n = 0;
    m = 6'h00;
    while (done !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      #1;
      n++;
      m |= sel;
    end
    start = 1'b0;
    chk("bus done", done, 1);
  endtask

  task automatic load_ws(input logic [1:0] v);
    @(posedge clk);
    #1;
    {wload, wset} = {1'b1, v};
    @(posedge clk);
    #1;
    wload = 1'b0;
  endtask

  task automatic t_reset();
    int n;
    logic [5:0] m;
    chk("ready", rdy, 1);
    chk("line enables", pp_oe, 0);
    cyc(1, 0, 16'h8000, 8'h00, n, m);
    chk("default wait len", n >= 24, 1);
  endtask

  task automatic t_waits();
    int n;
    int nt;
    logic [5:0] m;
    for (int ws = 0; ws < 4; ws++)
    begin
      load_ws(2'(ws));
      nt = 2 + (ws > 2 ? 2 : ws);
      cyc(1, 0, 16'hBFFF, 8'h00, n, m);
      chk("wait len", n >= 6 * nt && n <= 7 * nt + 9, 1);
    end
  endtask

  task automatic t_decode();
    int n;
    logic [5:0] m;
    load_ws(2'h0);
    for (int k = 0; k < 10; k++)
    begin
      cyc(k != 9, 0, TA[k], 8'h00, n, m);
      chk("select", m, TM[k]);
      chk("half len", n >= 24, k != 9 && !TA[k][15]);
    end
  endtask

  task automatic t_stretch();
    int n;
    logic [5:0] m;
    stall = 8'd40;
    cyc(1, 0, 16'h4100, 8'h00, n, m);
    stall = 8'd0;
    chk("stretch len", n >= 41, 1);
    chk("stretch sel", m, 6'h04);
  endtask

  task automatic t_ports();
    int n;
    logic [5:0] m;
    cyc(1, 1, 16'hC103, 8'h82, n, m);
    cyc(1, 1, 16'hC100, 8'hA5, n, m);
    cyc(1, 1, 16'hC102, 8'h3C, n, m);
    repeat (2) @(posedge clk);
    chk("mode enables", pp_oe, 24'hFF00FF);
    chk("port outs", {pp_out[23:16], pp_out[7:0]}, 16'h3CA5);
    cyc(1, 1, 16'hC103, 8'h9F, n, m);
    repeat (2) @(posedge clk);
    chk("input enables", pp_oe, 0);
    for (int k = 0; k < 3; k++)
    begin
      cyc(1, 0, 16'hC100 + 16'(k), 8'h00, n, m);
      chk("port read", rdata, pat[8*k +: 8]);
    end
    cyc(1, 0, 16'hC103, 8'h00, n, m);
    chk("command read", rdata, 0);
    cyc(1, 1, 16'hC103, 8'hA0, n, m);
    repeat (2) @(posedge clk);
    chk("strobed enables", pp_oe, 24'hBFFFFF);
    cyc(1, 1, 16'hC100, 8'h11, n, m);
    repeat (2) @(posedge clk);
    chk("obf after write", pp_out, 24'h000011);
    #1;
    pat[22] = 1'b0;
    repeat (5) @(posedge clk);
    chk("ack clears obf", pp_out, 24'h800011);
    cyc(1, 1, 16'hC103, 8'h01, n, m);
    repeat (2) @(posedge clk);
    chk("bit set", pp_out, 24'h810011);
  endtask

  task automatic summarize();
    if (n_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // whole run needs about a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      summarize();
    end
  end

  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_waits();
    t_decode();
    t_stretch();
    t_ports();
    summarize();
  end
endmodule
